// File: shared/ppr_regs.svh
`ifndef PPR_REGS_SVH
`define PPR_REGS_SVH
// Counts
`define PPR_NUM_FUNCS 23
`define PPR_NUM_PINS 32
`define PPR_NUM_SRCS 24
`define PPR_SEL_W 5
// Word indices on the bus
`define PPR_IDX_LOCK 6'h00
`define PPR_IDX_IN_BASE 6'h01
`define PPR_IDX_OUT_BASE 6'h20
// Lock register fields and unlock keys
`define PPR_LOCK_BIT 0
`define PPR_KEY_FIRST 8'h55
`define PPR_KEY_SECOND 8'hAA
// Output source codes
`define PPR_SRC_FIRST 5'h01
`define PPR_SRC_LAST 5'h18
// Reset values
`define PPR_OUT_SEL_RESET 5'h00
`define PPR_LOCK_RESET 1'h0
// Input function default pins, function 22 first down to function 0
`define PPR_IN_DEFAULTS {5'h00, 5'h00, 5'h16, 5'h17, 5'h00, 5'h14, 5'h13, 5'h00, \
  5'h0F, 5'h0E, 5'h01, 5'h00, 5'h12, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, \
  5'h00, 5'h00, 5'h00, 5'h00}
`endif

// File: shared/ppr_pkg.sv
`include "ppr_regs.svh"
package ppr_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_GOT_FIRST = 3'h2,
    SEQ_GOT_SECOND = 3'h4
  } ppr_seq_type;

  typedef logic [`PPR_NUM_FUNCS-1:0][`PPR_SEL_W-1:0] ppr_in_sel_type;
  typedef logic [`PPR_NUM_PINS-1:0][`PPR_SEL_W-1:0] ppr_out_sel_type;

  typedef struct packed {
    ppr_seq_type seq;
    logic lock;
    logic set_done;
    logic clr_done;
    logic ack;
    logic [7:0] rdata;
    ppr_in_sel_type in_sel;
    ppr_out_sel_type out_sel;
    logic [`PPR_NUM_PINS-1:0] s1;
    logic [`PPR_NUM_PINS-1:0] s2;
    logic [`PPR_NUM_PINS-1:0] s3;
    logic [`PPR_NUM_PINS-1:0] filt;
    logic [`PPR_NUM_FUNCS-1:0] func;
    logic [`PPR_NUM_PINS-1:0] pin_o;
    logic [`PPR_NUM_PINS-1:0] pin_oe;
  } ppr_state_type;
endpackage

// File: src/ppr_router.sv
// Summary of operation
// - Lock bit changes only after writes 0x55 then 0xAA to the lock register.
// - With one-shot fuse, lock may be cleared once and set once per reset.
// - With one-shot fuse, lock once set stays set until next device reset.
// - Sleep has no effect on any routing selection.
// - Power-on reset restores default selections and removes the permanent lock.
// - Non power-on resets leave all routing selections unchanged.
// - Output codes 0x01-0x0C select logic cells, wavegen, capcomp, pwm outputs.
// - Output codes 0x0D-0x18 select serial, comparator, timer, guard, calendar.
// - Input route registers hold 5 bits; bits 7 to 5 read zero.
// - Input route power-on value is the function default pin; kept otherwise.
// - Each input function has its own route register.
// - Input pin codes: port A bits 0-7 then port B bits 0-7, and on.
// - Output route registers: 5 bits, zero on power-on, kept otherwise.
// - A routed peripheral controls its pin direction only while its override input is set; otherwise the port direction is used.
// - Route registers ignore writes while locked, accept them while unlocked.
`include "ppr_regs.svh"
module ppr_router (
  // Clock and resets
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic dev_reset_in,
  // Configuration
  input wire logic one_shot_lock_fuse_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Status
  output logic route_locked_bit_out,
  // Pins
  input wire logic [`PPR_NUM_PINS-1:0] pin_in,
  input wire logic [`PPR_NUM_PINS-1:0] port_latch_in,
  input wire logic [`PPR_NUM_PINS-1:0] pin_direction_control_in,
  output logic [`PPR_NUM_PINS-1:0] pin_out,
  output logic [`PPR_NUM_PINS-1:0] pin_oe_out,
  // Peripheral signals
  input wire logic [`PPR_NUM_SRCS-1:0] src_data_in,
  input wire logic [`PPR_NUM_SRCS-1:0] src_oe_in,
  input wire logic [`PPR_NUM_SRCS-1:0] src_override_in,
  output logic [`PPR_NUM_FUNCS-1:0] func_out
);
  ppr_pkg::ppr_state_type r;
  ppr_pkg::ppr_state_type next_r;

  // Kind of register at a word index: 0 none, 1 lock, 2 input route, 3 output route
  function automatic logic [1:0] reg_kind(input logic [5:0] idx);
    if (idx == `PPR_IDX_LOCK)
      reg_kind = 2'h1;
    else if (idx >= `PPR_IDX_OUT_BASE)
      reg_kind = 2'h3;
    else if (idx < 6'(`PPR_NUM_FUNCS) + `PPR_IDX_IN_BASE)
      reg_kind = 2'h2;
    else
      reg_kind = 2'h0;
  endfunction

  // Valid peripheral source code for an output pin
  function automatic logic src_valid(input logic [4:0] code);
    src_valid = (code >= `PPR_SRC_FIRST) && (code <= `PPR_SRC_LAST);
  endfunction

  logic [5:0] idx;
  logic [1:0] kind;
  logic commit;
  logic [7:0] wbyte;
  logic [4:0] in_off;
  logic [4:0] out_off;

  assign idx = avs_address_in[7:2];
  assign kind = reg_kind(idx);
  assign commit = r.ack && (avs_read_in || avs_write_in);
  assign wbyte = avs_writedata_in[7:0];
  assign in_off = 5'(idx - `PPR_IDX_IN_BASE);
  assign out_off = 5'(idx - `PPR_IDX_OUT_BASE);
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !r.ack;
  assign avs_readdata_out = {24'h000000, r.rdata};
  assign route_locked_bit_out = r.lock;
  assign pin_out = r.pin_o;
  assign pin_oe_out = r.pin_oe;
  assign func_out = r.func;

  always_comb
  begin
    logic [4:0] code;
    code = 5'h00;
    next_r = r;
    // One wait cycle, then the answer
    next_r.ack = (avs_read_in || avs_write_in) && !r.ack;
    if ((avs_read_in || avs_write_in) && !r.ack)
    begin
      case (kind)
        2'h1: next_r.rdata = {7'h00, r.lock};
        2'h2: next_r.rdata = {3'h0, r.in_sel[in_off]};
        2'h3: next_r.rdata = {3'h0, r.out_sel[out_off]};
        default: next_r.rdata = 8'h00;
      endcase
    end
    if (commit)
    begin
      if (avs_write_in && kind == 2'h1)
      begin
        case (r.seq)
          ppr_pkg::SEQ_IDLE:
            next_r.seq = (wbyte == `PPR_KEY_FIRST) ? ppr_pkg::SEQ_GOT_FIRST
                                                     : ppr_pkg::SEQ_IDLE;
          ppr_pkg::SEQ_GOT_FIRST:
            if (wbyte == `PPR_KEY_SECOND)
              next_r.seq = ppr_pkg::SEQ_GOT_SECOND;
            else if (wbyte == `PPR_KEY_FIRST)
              next_r.seq = ppr_pkg::SEQ_GOT_FIRST;
            else
              next_r.seq = ppr_pkg::SEQ_IDLE;
          ppr_pkg::SEQ_GOT_SECOND:
          begin
            next_r.seq = ppr_pkg::SEQ_IDLE;
            if (!one_shot_lock_fuse_in)
              next_r.lock = wbyte[`PPR_LOCK_BIT];
            else if (wbyte[`PPR_LOCK_BIT] && !r.set_done)
            begin
              next_r.lock = 1'b1;
              next_r.set_done = 1'b1;
            end
            else if (!wbyte[`PPR_LOCK_BIT] && !r.clr_done && !r.set_done)
            begin
              next_r.lock = 1'b0;
              next_r.clr_done = 1'b1;
            end
          end
          default: next_r.seq = ppr_pkg::SEQ_IDLE;
        endcase
      end
      else
        next_r.seq = ppr_pkg::SEQ_IDLE;
      // Selections change only by an unlocked write; sleep has no path here
      if (avs_write_in && !r.lock)
      begin
        if (kind == 2'h2)
          next_r.in_sel[in_off] = wbyte[4:0];
        else if (kind == 2'h3)
          next_r.out_sel[out_off] = wbyte[4:0];
      end
    end
    // Pin input filter: a change counts once second and third stage agree
    next_r.s1 = pin_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int p = 0; p < `PPR_NUM_PINS; p++)
    begin
      if (r.s2[p] == r.s3[p])
        next_r.filt[p] = r.s3[p];
    end
    // Software keeps codes in range per function
    for (int f = 0; f < `PPR_NUM_FUNCS; f++)
      next_r.func[f] = r.filt[r.in_sel[f]];
    for (int p = 0; p < `PPR_NUM_PINS; p++)
    begin
      code = r.out_sel[p];
      if (src_valid(code))
      begin
        next_r.pin_o[p] = src_data_in[5'(code - `PPR_SRC_FIRST)];
        next_r.pin_oe[p] = src_override_in[5'(code - `PPR_SRC_FIRST)]
          ? src_oe_in[5'(code - `PPR_SRC_FIRST)] : pin_direction_control_in[p];
      end
      else
      begin
        next_r.pin_o[p] = port_latch_in[p];
        next_r.pin_oe[p] = pin_direction_control_in[p];
      end
    end
    // Device reset other than power-on: lock, sequence, one-shot history and ack only
    if (dev_reset_in)
    begin
      next_r.lock = `PPR_LOCK_RESET;
      next_r.seq = ppr_pkg::SEQ_IDLE;
      next_r.set_done = 1'b0;
      next_r.clr_done = 1'b0;
      next_r.ack = 1'b0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      r <= '0;
      r.seq <= ppr_pkg::SEQ_IDLE;
      r.lock <= `PPR_LOCK_RESET;
      r.in_sel <= `PPR_IN_DEFAULTS;
      r.out_sel <= '{default: `PPR_OUT_SEL_RESET};
    end
    else
      r <= next_r;
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  property p_lock_needs_seq;
    (r.lock != next_r.lock) && !dev_reset_in |-> r.seq == ppr_pkg::SEQ_GOT_SECOND && commit;
  endproperty
  a_lock_needs_seq: assert property (p_lock_needs_seq)
    else $error("lock bit changed without unlock sequence");

  property p_abort;
    commit && !(avs_write_in && kind == 2'h1) && !dev_reset_in
      |=> r.seq == ppr_pkg::SEQ_IDLE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("unlock sequence survived another access");

  property p_one_shot_hold;
    one_shot_lock_fuse_in && r.set_done && r.lock && !dev_reset_in |=> r.lock;
  endproperty
  a_one_shot_hold: assert property (p_one_shot_hold)
    else $error("one-shot lock was cleared");

  property p_set_once;
    one_shot_lock_fuse_in && r.set_done && !dev_reset_in |=> r.set_done && $stable(r.clr_done);
  endproperty
  a_set_once: assert property (p_set_once)
    else $error("one-shot history changed after set");

  property p_locked_stable;
    r.lock |=> $stable(r.in_sel) && $stable(r.out_sel);
  endproperty
  a_locked_stable: assert property (p_locked_stable)
    else $error("selection changed while locked");

  property p_dev_reset_keeps;
    dev_reset_in |=> $stable(r.in_sel) && $stable(r.out_sel) && !r.lock;
  endproperty
  a_dev_reset_keeps: assert property (p_dev_reset_keeps)
    else $error("device reset altered selections");

  property p_por_defaults;
    @(posedge clock_in) $fell(rst_in)
      |-> r.out_sel == '0 && r.in_sel == `PPR_IN_DEFAULTS && !r.lock;
  endproperty
  a_por_defaults: assert property (p_por_defaults)
    else $error("power-on defaults not restored");

  property p_latch_default;
    !src_valid(r.out_sel[0]) |=> pin_out[0] == $past(port_latch_in[0]);
  endproperty
  a_latch_default: assert property (p_latch_default)
    else $error("unrouted pin not driven from latch");

  property p_read_upper_zero;
    avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:5] == '0 || kind == 2'h1;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero)
    else $error("unimplemented bits read nonzero");

  property p_write_takes;
    commit && avs_write_in && !r.lock && kind == 2'h3 && !dev_reset_in
      |=> r.out_sel[$past(out_off)] == $past(wbyte[4:0]);
  endproperty
  a_write_takes: assert property (p_write_takes)
    else $error("unlocked route write lost");

  property p_in_write_takes;
    commit && avs_write_in && !r.lock && kind == 2'h2 && !dev_reset_in
      |=> r.in_sel[$past(in_off)] == $past(wbyte[4:0]);
  endproperty
  a_in_write_takes: assert property (p_in_write_takes)
    else $error("unlocked input route write lost");

  property p_seq_first;
    commit && avs_write_in && kind == 2'h1 && r.seq == ppr_pkg::SEQ_IDLE
      && wbyte == `PPR_KEY_FIRST && !dev_reset_in |=> r.seq == ppr_pkg::SEQ_GOT_FIRST;
  endproperty
  a_seq_first: assert property (p_seq_first)
    else $error("first unlock key not accepted");

  property p_clear_once;
    one_shot_lock_fuse_in && r.clr_done && !dev_reset_in |=> r.clr_done;
  endproperty
  a_clear_once: assert property (p_clear_once)
    else $error("one-shot clear history lost");

  property p_routed_out;
    src_valid(r.out_sel[0])
      |=> pin_out[0] == $past(src_data_in[5'(r.out_sel[0] - `PPR_SRC_FIRST)]);
  endproperty
  a_routed_out: assert property (p_routed_out)
    else $error("routed pin not driven from its source");

  property p_routed_oe;
    src_valid(r.out_sel[0]) && src_override_in[5'(r.out_sel[0] - `PPR_SRC_FIRST)]
      |=> pin_oe_out[0] == $past(src_oe_in[5'(r.out_sel[0] - `PPR_SRC_FIRST)]);
  endproperty
  a_routed_oe: assert property (p_routed_oe)
    else $error("peripheral did not take pin direction");

  property p_unrouted_oe;
    !src_valid(r.out_sel[0]) |=> pin_oe_out[0] == $past(pin_direction_control_in[0]);
  endproperty
  a_unrouted_oe: assert property (p_unrouted_oe)
    else $error("unrouted pin direction not from port");
endmodule

// File: bench/ppr_far_model.sv
module ppr_far_model #(
  parameter logic [23:0] DATA_PAT = 24'h000001,
  parameter logic [23:0] OE_PAT = 24'h000001,
  parameter logic [23:0] OV_PAT = 24'h000001
) (
  // Stimulus from the bench
  input wire logic invert_in,
  input wire logic [31:0] drive_pins_in,
  // Peripheral and pin side
  output logic [23:0] src_data_out,
  output logic [23:0] src_oe_out,
  output logic [23:0] src_override_out,
  output logic [31:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Inverted phase shows a stuck source bit
  assign src_data_out = DATA_PAT ^ {24{invert_in}};
  assign src_oe_out = OE_PAT ^ {24{invert_in}};
  assign src_override_out = OV_PAT;
  assign pin_level_out = drive_pins_in;
endmodule

// File: bench/tb_top.sv
`include "ppr_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] PAT_D = 24'h5AC396;
  localparam logic [23:0] PAT_O = 24'h33CC0F;
  localparam logic [23:0] PAT_V = 24'h0FF0A5;
  logic clock_in = 0, rst_in = 1, dev_reset_in = 0, fuse = 0, rd_en = 0, wr_en = 0, inv = 0;
  logic wt, locked, ed, eo;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, q, pins = 32'h0, latch = 32'h0, dir = 32'h1, pout, poe;
  logic [31:0] lv;
  logic [23:0] sd, so, sv;
  logic [22:0] func;
  int fail_count = 0, samples_checked = 0;
  ppr_far_model #(.DATA_PAT(PAT_D), .OE_PAT(PAT_O), .OV_PAT(PAT_V)) i_far (.invert_in(inv),
    .drive_pins_in(pins), .src_data_out(sd), .src_oe_out(so), .src_override_out(sv),
    .pin_level_out(lv));
  ppr_router i_dut (.clock_in(clock_in), .rst_in(rst_in), .dev_reset_in(dev_reset_in),
    .one_shot_lock_fuse_in(fuse), .avs_address_in(addr), .avs_read_in(rd_en),
    .avs_write_in(wr_en), .avs_writedata_in(wd), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .route_locked_bit_out(locked), .pin_in(lv),
    .port_latch_in(latch), .pin_direction_control_in(dir), .pin_out(pout), .pin_oe_out(poe),
    .src_data_in(sd), .src_oe_in(so), .src_override_in(sv), .func_out(func));
  initial
  begin
    forever #10 clock_in = ~clock_in;
  end
  task automatic wrap_up;
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr <= a;
    wr_en <= w;
    rd_en <= !w;
    wd <= {24'h0, d};
    do
    begin
      @(posedge clock_in);
      q = rdat;
      n++;
    end while (wt !== 1'b0 && n < 50);
    if (wt !== 1'b0)
      chk("waitrequest", 32'h0, 32'h1);
    wr_en <= 0;
    rd_en <= 0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, q);
  endtask
  task automatic unlock(input logic [7:0] d);
    wr(8'h00, 8'h55);
    wr(8'h00, 8'hAA);
    wr(8'h00, d);
  endtask
  task automatic pulse(input logic por);
    if (por)
      rst_in <= 1;
    else
      dev_reset_in <= 1;
    repeat (2) @(posedge clock_in);
    rst_in <= 0;
    dev_reset_in <= 0;
    @(posedge clock_in);
  endtask
  task automatic look(input int c);
    repeat (c) @(posedge clock_in);
    @(negedge clock_in);
  endtask
  initial
  begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge clock_in);
    rst_in <= 0;
    @(posedge clock_in);
    rd("lock", 8'h00, 8'h00);
    rd("out0", 8'h80, 8'h00);
    rd("cwg_in", 8'h2C, 8'h12);
    rd("clc2_in", 8'h38, 8'h0E);
    rd("rx1_in", 8'h50, 8'h17);
    rd("tx1_in", 8'h54, 8'h16);
    wr(8'h80, 8'hFF);
    rd("out0", 8'h80, 8'h1F);
    wr(8'h04, 8'hEF);
    rd("int_in", 8'h04, 8'h0F);
    rd("t0_in", 8'h08, 8'h00);
    wr(8'h60, 8'h07);
    rd("unmapped", 8'h60, 8'h00);
    for (int k = 0; k < 32; k++)
    begin
      wr(8'h80, 8'(k));
      for (int ph = 0; ph < 2; ph++)
      begin
        inv <= ph[0];
        latch <= {31'h0, ph[0]};
        dir <= {31'h0, !ph[0]};
        look(3);
        ed = (k >= 1 && k <= 24) ? PAT_D[k - 1] ^ ph[0] : ph[0];
        eo = (k >= 1 && k <= 24 && PAT_V[k - 1]) ? PAT_O[k - 1] ^ ph[0] : dir[0];
        chk("pin0_out", {31'h0, ed}, {31'h0, pout[0]});
        chk("pin0_oe", {31'h0, eo}, {31'h0, poe[0]});
        @(posedge clock_in);
      end
    end
    pins <= 32'h0000_8000;
    look(8);
    chk("int_func", 32'h1, {31'h0, func[0]});
    @(posedge clock_in);
    pins <= 32'h0;
    look(8);
    chk("int_func", 32'h0, {31'h0, func[0]});
    @(posedge clock_in);
    unlock(8'h01);
    rd("lock", 8'h00, 8'h01);
    wr(8'h80, 8'h05);
    rd("out0", 8'h80, 8'h1F);
    wr(8'h00, 8'h00);
    rd("lock", 8'h00, 8'h01);
    wr(8'h00, 8'h55);
    rd("out0", 8'h80, 8'h1F);
    wr(8'h00, 8'hAA);
    wr(8'h00, 8'h00);
    rd("lock", 8'h00, 8'h01);
    unlock(8'h00);
    rd("lock", 8'h00, 8'h00);
    chk("locked", 32'h0, {31'h0, locked});
    wr(8'h80, 8'h05);
    rd("out0", 8'h80, 8'h05);
    pulse(1'b0);
    rd("out0", 8'h80, 8'h05);
    rd("int_in", 8'h04, 8'h0F);
    fuse <= 1;
    unlock(8'h00);
    unlock(8'h01);
    rd("lock", 8'h00, 8'h01);
    unlock(8'h00);
    rd("lock", 8'h00, 8'h01);
    pulse(1'b0);
    unlock(8'h01);
    rd("lock", 8'h00, 8'h01);
    pulse(1'b1);
    rd("out0", 8'h80, 8'h00);
    rd("int_in", 8'h04, 8'h00);
    rd("lock", 8'h00, 8'h00);
    wr(8'h84, 8'h0B);
    rd("out1", 8'h84, 8'h0B);
    wr(8'h44, 8'h03);
    wr(8'h8C, 8'h13);
    pins <= 32'h0000_0008;
    look(8);
    chk("ssp_clk_in", 32'h1, {31'h0, func[16]});
    chk("pin3_out", {31'h0, PAT_D[18] ^ inv}, {31'h0, pout[3]});
    @(posedge clock_in);
    wrap_up();
  end
endmodule
